//--- traffic_map.vh
`ifndef TRAFFIC_MAP_VH
`define TRAFFIC_MAP_VH
// register offsets (byte addresses, one word each)
`define REG_TX_SOURCE     8'h00
`define REG_GEN_MODE      8'h04
`define REG_FRAME_SIZE    8'h08
`define REG_PAUSE_LEN     8'h0C
`define REG_COMMAND       8'h10
`define REG_RX_CONFIG     8'h14
`define REG_FILT_INDEX    8'h18
`define REG_FILT_LOW      8'h1C
`define REG_FILT_HIGH     8'h20
`define REG_STATUS        8'h24
`define REG_EDIT_ADDR     8'h28
`define REG_EDIT_DATA     8'h2C
`define REG_EDIT_LEN      8'h30
// transmit source codes
`define SRC_LOOP          2'h0
`define SRC_SWAP          2'h1
`define SRC_GEN           2'h2
`define SRC_EDIT          2'h3
// generator mode bit positions
`define MODE_LENGTH       0
`define MODE_VLAN         1
`define MODE_CORRUPT      2
`define MODE_SWEEP        3
`define MODE_PASS_CRC     4
// command bit positions
`define CMD_CONT          0
`define CMD_STOP          1
`define CMD_TEN           2
`define CMD_SINGLE        3
`define CMD_PAUSE         4
// frame figures
`define TYPE_VALUE        16'h0800
`define SWEEP_START       11'h013
`define BURST_TEN         4'hA
`define ADDR_BYTES        4'h6
`define HDR_BYTES         11'h00E
`define VLAN_BYTES        11'h004
`define DEST_ADDR         48'h112233445566
`define SRC_ADDR_DEFAULT  48'h020000000001 // arbitrary
`define FRAME_SIZE_RESET  11'h040
`define FILTER_ENTRIES    4
`endif

//--- swap_buffer.v
`timescale 1ns/1ps
`default_nettype none
`include "traffic_map.vh"
// loopback path; in swap mode holds the first six bytes back and emits
// them after the next six so destination and source trade places
module swap_buffer (
   // clock and reset
   input  wire       clock,
   input  wire       reset_n,
   // control
   input  wire       swap,
   // receive side
   input  wire [7:0] in_data,
   input  wire       in_valid,
   input  wire       in_last,
   output wire       in_ready,
   // transmit side
   output reg  [7:0] out_data,
   output reg        out_valid,
   output reg        out_last,
   input  wire       out_ready
);
   reg [7:0]  hold [0:5];
   reg [3:0]  count;
   reg [2:0]  replay;
   reg        replaying;

   // stall input while the held addresses replay
   assign in_ready = (~out_valid | out_ready) & ~replaying;

   // byte counter, hold store and output register
   always @(posedge clock) begin
      if (!reset_n) begin
         count     <= 4'h0;
         replay    <= 3'h0;
         replaying <= 1'b0;
         out_data  <= 8'h00;
         out_valid <= 1'b0;
         out_last  <= 1'b0;
      end else begin
         if (out_valid & out_ready)
            out_valid <= 1'b0;
         if (replaying & (~out_valid | out_ready)) begin
            out_data  <= hold[replay];
            out_valid <= 1'b1;
            out_last  <= 1'b0;
            replay    <= replay + 3'h1;
            if (replay == 3'h5)
               replaying <= 1'b0;
         end else if (in_valid & in_ready) begin
            if (swap & (count < `ADDR_BYTES) & ~in_last) begin
               hold[count[2:0]] <= in_data;
               count <= count + 4'h1;
            end else begin
               out_data  <= in_data;
               out_valid <= 1'b1;
               out_last  <= in_last;
               if (in_last)
                  count <= 4'h0;
               else if (count != 4'hF)
                  count <= count + 4'h1;
               // after byte twelve the held bytes go out
               if (swap & (count == 4'hB) & ~in_last) begin
                  replaying <= 1'b1;
                  replay    <= 3'h0;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- pattern_generator.v
`timescale 1ns/1ps
`default_nettype none
`include "traffic_map.vh"
// builds one frame per start pulse: header, optional tag, counting payload
module pattern_generator (
   // clock and reset
   input  wire        clock,
   input  wire        reset_n,
   // settings
   input  wire [10:0] frame_size,
   input  wire [4:0]  mode,
   // control
   input  wire        start,
   output wire        busy,
   output reg         frame_done,
   // stream out
   output reg  [7:0]  out_data,
   output reg         out_valid,
   output reg         out_last,
   input  wire        out_ready
);
   reg [10:0] pos;
   reg [10:0] length;
   reg [10:0] sweep;
   reg        running;
   wire [10:0] hdr;
   wire [10:0] payload;
   wire [15:0] len_type;
   wire [95:0] addr_pair;
   reg  [7:0]  next_byte;

   assign busy = running | out_valid;
   assign addr_pair = {`DEST_ADDR, `SRC_ADDR_DEFAULT};
   assign hdr  = mode[`MODE_VLAN] ? (`HDR_BYTES + `VLAN_BYTES) : `HDR_BYTES;
   // vlan tag takes room from payload, total stays put
   assign payload = (length > hdr) ? (length - hdr) : 11'h000;
   assign len_type = mode[`MODE_CORRUPT] ? {5'h00, payload} + 16'h0001 :
                     mode[`MODE_LENGTH]  ? {5'h00, payload} :
                     `TYPE_VALUE;

   // byte at current position
   always @* begin
      next_byte = pos[7:0];
      if (pos < 11'h00C)
         next_byte = addr_pair[7'd95 - {pos[3:0], 3'h0} -: 8];
      else if (mode[`MODE_VLAN] && pos == 11'h00C)
         next_byte = 8'h81;
      else if (mode[`MODE_VLAN] && pos < 11'h010)
         next_byte = 8'h00;
      else if (pos == hdr - 11'h002)
         next_byte = len_type[15:8];
      else if (pos == hdr - 11'h001)
         next_byte = len_type[7:0];
   end

   // frame walker
   always @(posedge clock) begin
      if (!reset_n) begin
         pos        <= 11'h000;
         length     <= `FRAME_SIZE_RESET;
         sweep      <= `SWEEP_START;
         running    <= 1'b0;
         frame_done <= 1'b0;
         out_data   <= 8'h00;
         out_valid  <= 1'b0;
         out_last   <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (out_valid & out_ready) begin
            out_valid <= 1'b0;
            if (out_last)
               frame_done <= 1'b1;
         end
         if (start & ~busy) begin
            running <= 1'b1;
            pos     <= 11'h000;
            length  <= mode[`MODE_SWEEP] ? sweep : frame_size;
            if (mode[`MODE_SWEEP])
               sweep <= (sweep >= frame_size) ? `SWEEP_START : sweep + 11'h001;
         end else if (running & (~out_valid | out_ready)) begin
            out_data  <= next_byte;
            out_valid <= 1'b1;
            out_last  <= (pos == length - 11'h001);
            pos       <= pos + 11'h001;
            if (pos == length - 11'h001)
               running <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- traffic_source.v
// Summary of operation
// - mac transmit fed by exactly one source: loopback, generator or editor
// - looped frames go receiver to swap buffer to transmit output register to mac
// - swap loopback exchanges first six bytes with next six bytes
// - generator source drives the transmit output register through the source mux
// - editor source sends the frame held in a user ram
// - phy loopback receive source returns transmit data through the phy
// - type mode writes 0800 into the length/type field
// - length mode writes payload byte count into length/type field
// - vlan mode adds a tag, keeps total size, lowers length field
// - corrupt length writes a wrong length value
// - sweep starts at 19 bytes, grows by one, wraps at frame size
// - frame size sets total generated size; mac pads below 60
// - sixteen bit pause length drives the mac pause length input
// - continuous command sends frames until stop command
// - ten frame command sends exactly ten frames then stops
// - single frame command sends exactly one frame
// - pause command pulses the mac pause request
// - transmit commands act only while generator source is selected
// - generator frames carry destination 11-22-33-44-55-66
// - address filter switchable, table entries writable
// - valid crc passing hands the full frame on with its crc
`timescale 1ns/1ps
`default_nettype none
`include "traffic_map.vh"
module traffic_source (
   // clock and reset
   input  wire        clock,
   input  wire        reset_n,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   // mac client receive
   input  wire [7:0]  rx_data,
   input  wire        rx_valid,
   input  wire        rx_last,
   output wire        rx_ready,
   // mac client transmit
   output reg  [7:0]  tx_data,
   output reg         tx_valid,
   output reg         tx_last,
   input  wire        tx_ready,
   // mac side controls
   output reg  [15:0] pause_length,
   output reg         pause_request,
   output reg         phy_loopback,
   output reg         tx_pass_fcs,
   output reg         rx_pass_fcs,
   output reg         filter_enable,
   output reg  [47:0] filter_addr,
   output reg  [1:0]  filter_index,
   output reg         filter_write
);
   // editor store
   reg [7:0]  edit_ram [0:2047];
   reg [10:0] edit_addr;
   reg [10:0] edit_len;
   reg [10:0] edit_pos;
   reg        edit_run;
   reg        edit_go;

   // configuration
   reg [1:0]  src_req;
   reg [1:0]  src_active;
   reg        in_frame;
   reg [4:0]  gen_mode;
   reg [10:0] frame_size;
   reg [1:0]  filt_sel;
   reg [31:0] filt_low;
   reg [15:0] filt_high;

   // generator run control
   reg        continuous;
   reg [3:0]  remaining;
   reg [15:0] frames_sent;

   wire       gen_busy;
   wire       gen_done;
   wire [7:0] gen_data;
   wire       gen_valid;
   wire       gen_last;
   wire       gen_ready;
   wire [7:0] loop_data;
   wire       loop_valid;
   wire       loop_last;
   wire       loop_ready;
   wire       gen_start;
   wire       gen_selected;
   reg  [7:0] sel_data;
   reg        sel_valid;
   reg        sel_last;
   wire       take;

   localparam [1:0] CMD_IDLE = 2'h0;

   function is_write;
      input [7:0] addr;
      input [7:0] target;
      begin
         is_write = reg_write & (addr == target);
      end
   endfunction

   assign gen_selected = (src_active == `SRC_GEN);

   // loopback path with optional address swap
   swap_buffer loop_path (
      .clock     (clock),
      .reset_n   (reset_n),
      .swap      (src_active == `SRC_SWAP),
      .in_data   (rx_data),
      .in_valid  (rx_valid & ~src_active[1]),
      .in_last   (rx_last),
      .in_ready  (loop_ready),
      .out_data  (loop_data),
      .out_valid (loop_valid),
      .out_last  (loop_last),
      .out_ready (take & ~src_active[1])
   );

   // received frames are sunk when loopback is not the source
   assign rx_ready = src_active[1] ? 1'b1 : loop_ready;

   assign gen_start = gen_selected & (continuous | (remaining != 4'h0)) & ~gen_busy;

   pattern_generator generator (
      .clock      (clock),
      .reset_n    (reset_n),
      .frame_size (frame_size),
      .mode       (gen_mode),
      .start      (gen_start),
      .busy       (gen_busy),
      .frame_done (gen_done),
      .out_data   (gen_data),
      .out_valid  (gen_valid),
      .out_last   (gen_last),
      .out_ready  (gen_ready)
   );
   assign gen_ready = take & gen_selected;

   // one source multiplexed to the mac; only the active one is heard
   always @* begin
      case (src_active)
         `SRC_GEN: begin
            sel_data  = gen_data;
            sel_valid = gen_valid;
            sel_last  = gen_last;
         end
         `SRC_EDIT: begin
            sel_data  = edit_ram[edit_pos];
            sel_valid = edit_run;
            sel_last  = (edit_pos == edit_len - 11'h001);
         end
         default: begin
            sel_data  = loop_data;
            sel_valid = loop_valid;
            sel_last  = loop_last;
         end
      endcase
   end

   assign take = ~tx_valid | tx_ready;

   // transmit output register
   always @(posedge clock) begin
      if (!reset_n) begin
         tx_data  <= 8'h00;
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
      end else if (take) begin
         tx_data  <= sel_data;
         tx_valid <= sel_valid;
         tx_last  <= sel_last;
      end
   end

   // track frame boundaries; source switches only while idle
   always @(posedge clock) begin
      if (!reset_n) begin
         in_frame   <= 1'b0;
         src_active <= `SRC_LOOP;
      end else begin
         if (take & sel_valid)
            in_frame <= ~sel_last;
         if (~in_frame & ~(take & sel_valid) & ~gen_busy & ~edit_run & ~loop_valid)
            src_active <= src_req;
      end
   end

   // editor ram fill and replay
   always @(posedge clock) begin
      if (!reset_n) begin
         edit_addr <= 11'h000;
         edit_len  <= 11'h000;
         edit_pos  <= 11'h000;
         edit_run  <= 1'b0;
         edit_go   <= 1'b0;
      end else begin
         edit_go <= 1'b0;
         if (is_write(reg_addr, `REG_EDIT_ADDR))
            edit_addr <= reg_wdata[10:0];
         if (is_write(reg_addr, `REG_EDIT_DATA)) begin
            edit_ram[edit_addr] <= reg_wdata[7:0];
            edit_addr <= edit_addr + 11'h001;
         end
         if (is_write(reg_addr, `REG_EDIT_LEN)) begin
            edit_len <= reg_wdata[10:0];
            edit_go  <= reg_wdata[31];
         end
         if (edit_go & (src_active == `SRC_EDIT) & ~edit_run & (edit_len != 11'h000)) begin
            edit_run <= 1'b1;
            edit_pos <= 11'h000;
         end else if (edit_run & take & (src_active == `SRC_EDIT)) begin
            edit_pos <= edit_pos + 11'h001;
            if (edit_pos == edit_len - 11'h001)
               edit_run <= 1'b0;
         end
      end
   end

   // configuration writes and generator commands
   always @(posedge clock) begin
      if (!reset_n) begin
         src_req       <= `SRC_LOOP;
         gen_mode      <= 5'h00;
         frame_size    <= `FRAME_SIZE_RESET;
         pause_length  <= 16'h0000;
         pause_request <= 1'b0;
         phy_loopback  <= 1'b0;
         tx_pass_fcs   <= 1'b0;
         rx_pass_fcs   <= 1'b0;
         filter_enable <= 1'b0;
         filter_addr   <= 48'h000000000000;
         filter_index  <= 2'h0;
         filter_write  <= 1'b0;
         filt_sel      <= 2'h0;
         filt_low      <= 32'h00000000;
         filt_high     <= 16'h0000;
         continuous    <= 1'b0;
         remaining     <= 4'h0;
         frames_sent   <= 16'h0000;
      end else begin
         pause_request <= 1'b0;
         filter_write  <= 1'b0;
         if (gen_done) begin
            frames_sent <= frames_sent + 16'h0001;
         end
         // count one-shot frames as they start
         if (gen_start & ~continuous & (remaining != 4'h0))
            remaining <= remaining - 4'h1;
         if (is_write(reg_addr, `REG_TX_SOURCE))
            src_req <= reg_wdata[1:0];
         if (is_write(reg_addr, `REG_GEN_MODE)) begin
            gen_mode    <= reg_wdata[4:0];
            tx_pass_fcs <= reg_wdata[`MODE_PASS_CRC];
            rx_pass_fcs <= reg_wdata[`MODE_PASS_CRC];
         end
         if (is_write(reg_addr, `REG_FRAME_SIZE))
            frame_size <= reg_wdata[10:0];
         if (is_write(reg_addr, `REG_PAUSE_LEN))
            pause_length <= reg_wdata[15:0];
         if (is_write(reg_addr, `REG_RX_CONFIG)) begin
            phy_loopback  <= reg_wdata[0];
            filter_enable <= reg_wdata[1];
         end
         if (is_write(reg_addr, `REG_FILT_INDEX))
            filt_sel <= reg_wdata[1:0];
         if (is_write(reg_addr, `REG_FILT_LOW))
            filt_low <= reg_wdata;
         // high half commits the entry to the mac table
         if (is_write(reg_addr, `REG_FILT_HIGH)) begin
            filt_high    <= reg_wdata[15:0];
            filter_addr  <= {reg_wdata[15:0], filt_low};
            filter_index <= filt_sel;
            filter_write <= 1'b1;
         end
         // commands ignored unless the generator is the source
         if (is_write(reg_addr, `REG_COMMAND) & gen_selected) begin
            if (reg_wdata[`CMD_STOP])
               continuous <= 1'b0;
            else if (reg_wdata[`CMD_CONT])
               continuous <= 1'b1;
            if (reg_wdata[`CMD_TEN])
               remaining <= `BURST_TEN;
            else if (reg_wdata[`CMD_SINGLE])
               remaining <= 4'h1;
            if (reg_wdata[`CMD_PAUSE])
               pause_request <= 1'b1;
         end
         if (~gen_selected)
            continuous <= 1'b0;
      end
   end

   // read back, data one cycle after the strobe
   always @(posedge clock) begin
      if (!reset_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            `REG_TX_SOURCE:  reg_rdata <= {28'h0000000, src_active, src_req};
            `REG_GEN_MODE:   reg_rdata <= {27'h0000000, gen_mode};
            `REG_FRAME_SIZE: reg_rdata <= {21'h000000, frame_size};
            `REG_PAUSE_LEN:  reg_rdata <= {16'h0000, pause_length};
            `REG_RX_CONFIG:  reg_rdata <= {30'h00000000, filter_enable, phy_loopback};
            `REG_FILT_INDEX: reg_rdata <= {30'h00000000, filt_sel};
            `REG_FILT_LOW:   reg_rdata <= filt_low;
            `REG_FILT_HIGH:  reg_rdata <= {16'h0000, filt_high};
            `REG_STATUS:     reg_rdata <= {frames_sent, 6'h00, edit_run, in_frame,
                                           continuous, gen_busy, remaining, CMD_IDLE};
            `REG_EDIT_ADDR:  reg_rdata <= {21'h000000, edit_addr};
            `REG_EDIT_LEN:   reg_rdata <= {20'h00000, edit_run, edit_len};
            default:         reg_rdata <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- traffic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module traffic_monitor (
   // clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // register port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   // mac side
   input wire logic [7:0]  tx_data,
   input wire logic        tx_valid,
   input wire logic        tx_last,
   input wire logic        tx_ready,
   input wire logic [15:0] pause_length,
   input wire logic        pause_request,
   input wire logic        phy_loopback,
   input wire logic        filter_enable,
   input wire logic        filter_write
);
   logic [1:0] since_pause;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // age of the last pause command, saturating
   always @(posedge clock) begin
      if (!reset_n)
         since_pause <= 2'h3;
      else if (reg_write && reg_addr == 8'h10 && reg_wdata[4])
         since_pause <= 2'h0;
      else if (since_pause != 2'h3)
         since_pause <= since_pause + 2'h1;
   end
   chk_pause_pulse: assert property (pause_request |=> !pause_request)
      else $error("pause request longer than one cycle");
   chk_pause_cause: assert property (pause_request |-> since_pause <= 2'h2)
      else $error("pause request without a pause command");
   chk_pause_len: assert property (reg_write && reg_addr == 8'h0C |=>
      pause_length == $past(reg_wdata[15:0])) else $error("pause length not applied");
   chk_filter_commit: assert property (reg_write && reg_addr == 8'h20 |=> filter_write)
      else $error("filter entry not committed");
   chk_filter_pulse: assert property (filter_write |=> !filter_write)
      else $error("filter write longer than one cycle");
   chk_rx_config: assert property (reg_write && reg_addr == 8'h14 |=>
      phy_loopback == $past(reg_wdata[0]) && filter_enable == $past(reg_wdata[1]))
      else $error("receive configuration not applied");
   chk_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx byte dropped");
   chk_reset_quiet: assert property ($rose(reset_n) |->
      !tx_valid && !pause_request && !filter_write) else $error("output busy after reset");
   cover property (pause_request);
   cover property (filter_write);
   cover property (tx_valid && tx_ready && tx_last);
endmodule
bind traffic_source traffic_monitor u_traffic_monitor (.clock, .reset_n, .reg_addr,
   .reg_wdata, .reg_write, .tx_data, .tx_valid, .tx_last, .tx_ready, .pause_length,
   .pause_request, .phy_loopback, .filter_enable, .filter_write);
`default_nettype wire

//--- mac_client_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_client_model (
   // clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // pacing
   input wire logic       slow,
   // transmit from block
   input wire logic [7:0] tx_data,
   input wire logic       tx_valid,
   input wire logic       tx_last,
   output logic           tx_ready,
   // receive into block
   output logic [7:0]     rx_data,
   output logic           rx_valid,
   output logic           rx_last,
   input wire logic       rx_ready
);
   logic [7:0] frame_bytes [0:2047];
   integer     lens [0:15];
   integer     nbytes, frames, last_len;
   initial begin
      {tx_ready, rx_valid, rx_last, rx_data} = 11'h000;
      {nbytes, frames, last_len} = 96'h0;
   end
   // slow pacing stalls every other cycle
   always @(posedge clock) begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      if (!reset_n)
         nbytes = 0;
      else if (tx_valid && tx_ready) begin
         frame_bytes[nbytes] = tx_data;
         nbytes = nbytes + 1;
         if (tx_last) begin
            last_len = nbytes;
            lens[frames % 16] = nbytes;
            frames = frames + 1;
            nbytes = 0;
         end
      end
   end
   // byte stands until ready seen at an edge
   task automatic send_rx(input integer len);
      for (int i = 0; i < len; i++) begin
         rx_data <= i[7:0];
         rx_valid <= 1'b1;
         rx_last <= (i == len - 1);
         do @(posedge clock); while (!rx_ready);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
   endtask
endmodule
`default_nettype wire

//--- tb_traffic_source.sv
`timescale 1ns/1ps
`default_nettype none
module tb_traffic_source;
   logic        clock, reset_n, reg_write, reg_read, slow;
   logic [7:0]  reg_addr, rx_data, tx_data;
   logic [31:0] reg_wdata, reg_rdata;
   logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   logic [15:0] pause_length;
   logic        pause_request, phy_loopback, tx_pass_fcs, rx_pass_fcs;
   logic        filter_enable, filter_write;
   logic [47:0] filter_addr;
   logic [1:0]  filter_index;
   integer      errors, check_count, cycles, pauses, base, n, i, k, e;
   // generator rows: mode, frame size, expected length/type field
   logic [31:0] rows [0:4] = '{32'h00400800, 32'h01400032, 32'h01140006,
                              32'h0340002E, 32'h05400033};
   traffic_source u_traffic_source (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .rx_data, .rx_valid, .rx_last, .rx_ready, .tx_data, .tx_valid,
      .tx_last, .tx_ready, .pause_length, .pause_request, .phy_loopback, .tx_pass_fcs,
      .rx_pass_fcs, .filter_enable, .filter_addr, .filter_index, .filter_write);
   mac_client_model u_mac_client_model (.clock, .reset_n, .slow, .tx_data, .tx_valid,
      .tx_last, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_ready);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 compare(reg_rdata, exp);
   endtask
   task automatic wait_frames(input integer cnt);
      while (u_mac_client_model.frames < cnt)
         @(posedge clock);
   endtask
   function automatic logic [7:0] fb(input integer x);
      return u_mac_client_model.frame_bytes[x];
   endfunction
   // hang guard and pause pulse count
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (pause_request)
         pauses <= pauses + 1;
      if (cycles == 60000) begin
         errors = errors + 1;
         end_sim;
      end
   end
   initial begin
      {reg_write, reg_read, reg_addr, reg_wdata, slow} = 43'h0;
      {errors, check_count, cycles, pauses} = 128'h0;
      reset_n = 1'b0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      wr(8'h00, 32'h2);
      repeat (4) @(posedge clock);
      // one single frame per row
      for (i = 0; i < 5; i++) begin
         base = u_mac_client_model.frames;
         wr(8'h04, {24'h0, rows[i][31:24]});
         wr(8'h08, {24'h0, rows[i][23:16]});
         wr(8'h10, 32'h8);
         wait_frames(base + 1);
         compare(u_mac_client_model.last_len, rows[i][23:16]);
         compare({fb(0), fb(1), fb(2), fb(3)}, 32'h11223344);
         compare({fb(4), fb(5)}, 32'h5566);
         k = rows[i][25] ? 16 : 12;
         if (rows[i][25])
            compare({fb(12), fb(13)}, 32'h8100);
         compare({fb(k), fb(k + 1)}, rows[i][15:0]);
         $display("row %0d done", i);
      end
      slow <= 1'b1;
      base = u_mac_client_model.frames;
      wr(8'h10, 32'h4);
      wait_frames(base + 10);
      repeat (300) @(posedge clock);
      compare(u_mac_client_model.frames - base, 10);
      $display("ten frame test done");
      base = u_mac_client_model.frames;
      wr(8'h10, 32'h1);
      wait_frames(base + 3);
      wr(8'h10, 32'h2);
      repeat (300) @(posedge clock);
      n = u_mac_client_model.frames;
      repeat (300) @(posedge clock);
      compare(u_mac_client_model.frames, n);
      $display("continuous test done");
      wr(8'h04, 32'h19);
      wr(8'h08, 32'd22);
      base = u_mac_client_model.frames;
      wr(8'h10, 32'h1);
      wait_frames(base + 6);
      wr(8'h10, 32'h2);
      for (k = 0; k < 5; k++)
         compare(u_mac_client_model.lens[(base + k) % 16], k < 4 ? 19 + k : 19);
      repeat (300) @(posedge clock);
      $display("sweep test done");
      wr(8'h0C, 32'hABCD);
      @(negedge clock);
      compare(pause_length, 32'hABCD);
      n = pauses;
      wr(8'h10, 32'h10);
      repeat (5) @(posedge clock);
      compare(pauses - n, 1);
      wr(8'h00, 32'h0);
      repeat (10) @(posedge clock);
      base = u_mac_client_model.frames;
      n = pauses;
      wr(8'h10, 32'h18);
      repeat (200) @(posedge clock);
      compare(u_mac_client_model.frames, base);
      compare(pauses, n);
      $display("pause and source gating done");
      // plain then swapped loopback of a counting frame
      for (i = 0; i < 2; i++) begin
         wr(8'h00, i);
         repeat (10) @(posedge clock);
         base = u_mac_client_model.frames;
         u_mac_client_model.send_rx(20);
         wait_frames(base + 1);
         for (k = 0; k < 20; k++) begin
            e = (i == 0 || k > 11) ? k : (k < 6 ? k + 6 : k - 6);
            compare(fb(k), e);
         end
      end
      $display("loopback test done");
      wr(8'h18, 32'h2);
      wr(8'h1C, 32'h33445566);
      wr(8'h20, 32'h1122);
      wr(8'h14, 32'h3);
      @(negedge clock);
      compare(filter_addr[31:0], 32'h33445566);
      compare({filter_index, filter_addr[47:32]}, 32'h21122);
      compare({tx_pass_fcs, rx_pass_fcs, phy_loopback, filter_enable}, 32'hF);
      rd(8'hFC, 32'h0);
      $display("filter and register test done");
      wr(8'h00, 32'h2);
      repeat (10) @(posedge clock);
      wr(8'h10, 32'h1);
      repeat (40) @(posedge clock);
      reset_n <= 1'b0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      @(negedge clock);
      compare({tx_valid, pause_length, filter_write}, 32'h0);
      wr(8'h00, 32'h2);
      repeat (10) @(posedge clock);
      base = u_mac_client_model.frames;
      wr(8'h10, 32'h8);
      wait_frames(base + 1);
      compare(u_mac_client_model.last_len, 64);
      wr(8'h00, 32'h3);
      for (k = 0; k < 3; k++)
         wr(8'h2C, 32'hA0 + k);
      wr(8'h30, 32'h80000003);
      wait_frames(base + 2);
      compare({fb(0), fb(1), fb(2)}, 32'hA0A1A2);
      $display("reset test done");
      end_sim;
   end
endmodule
`default_nettype wire
